/* File: hw/pcs_lane_codec.sv */
// One lane of 8B/10B coding with bit flips, reversal, polarity, bitslip and a register port.
`default_nettype none
module pcs_lane_codec
    import pcs_lane_pkg::*;
#(
    parameter int BYTES  = DATA_BYTES_DEF,
    parameter int SLIP_W = SLIP_W_DEF,
    parameter bit HAS_TX = 1'b1
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    output logic                       irq,
    input  wire logic [BYTES*8-1:0]    tx_data,
    input  wire logic [BYTES-1:0]      tx_ctrl,
    input  wire logic [BYTES-1:0]      tx_force_disp,
    input  wire logic [BYTES-1:0]      tx_disp_val,
    input  wire logic                  tx_inv_polarity,
    input  wire logic [SLIP_W-1:0]     tx_slip_sel,
    output logic [BYTES*10-1:0]        ser_word,
    input  wire logic                  rx_valid,
    input  wire logic [BYTES*10-1:0]   rx_ser_word,
    output logic                       rx_out_valid,
    output logic [BYTES*8-1:0]         rx_data,
    output logic [BYTES-1:0]           rx_ctrl_det,
    output logic [BYTES-1:0]           rx_err_det,
    output logic [BYTES-1:0]           rx_disp_err,
    output logic [BYTES-1:0]           rx_run_disp
);
    localparam int  SER_W    = BYTES * 10;
    localparam bit  CODEC_OK = (BYTES == 1) || (BYTES == 2) || (BYTES == 4);

    cfg_type              cfg_r;
    irq_type              irq_stat_r;
    irq_type              irq_mask_r;
    irq_type              irq_ev;
    logic                 codec_on;
    logic                 tx_rd_r;
    logic                 tx_rd_nxt;
    logic                 rx_rd_r;
    logic                 rx_rd_nxt;
    logic [SER_W-1:0]     tx_sym;
    logic [SER_W-1:0]     tx_pre;
    logic [SER_W-1:0]     tx_prev_r;
    logic [SER_W-1:0]     ser_nxt;
    logic [BYTES*8-1:0]   tx_flipped;
    logic [BYTES*8-1:0]   rx_dec_data;
    logic [BYTES*8-1:0]   rx_data_nxt;
    logic [BYTES-1:0]     rx_k;
    logic [BYTES-1:0]     rx_v;
    logic [BYTES-1:0]     rx_d;
    logic [BYTES-1:0]     rx_rdb;
    logic                 ph_wr_r;
    logic                 ph_rd_r;
    logic [7:0]           ph_addr_r;

    // Count of ones in a group of up to ten bits.
    function automatic logic [3:0] pop(input logic [9:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 10; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    // Six-bit form for positive disparity: unbalanced groups and D7 invert.
    function automatic logic [5:0] alt6(input logic [5:0] t);
        return ((pop({4'h0, t}) != 4'h3) || (t == D7_6B)) ? ~t : t;
    endfunction

    // Encode one byte; returns {disparity after, ten-bit group abcdeifghj}.
    function automatic logic [10:0] enc_byte(input logic [7:0] d, input logic k, input logic rd);
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] c6;
        logic [3:0] c4;
        logic       kv;
        logic       r;
        x  = d[4:0];
        y  = d[7:5];
        kv = k && ((x == 5'h1c) || ((y == 3'h7) && ((x == 5'h17) || (x == 5'h1b) || (x == 5'h1d) || (x == 5'h1e))));
        if (kv && (x == 5'h1c)) begin
            c6 = rd ? ~K28_6B : K28_6B;
        end else begin
            c6 = rd ? alt6(T6_TAB[x*6 +: 6]) : T6_TAB[x*6 +: 6];
        end
        r = (pop({4'h0, c6}) == 4'h3) ? rd : ~rd;
        if (kv) begin
            c4 = r ? ~T4K_TAB[y*4 +: 4] : T4K_TAB[y*4 +: 4];
        end else begin
            c4 = T4D_TAB[y*4 +: 4];
            if ((y == 3'h7) && ((!r && ((x == 5'h11) || (x == 5'h12) || (x == 5'h14))) ||
                                (r && ((x == 5'h0b) || (x == 5'h0d) || (x == 5'h0e))))) begin
                c4 = A7_4B;
            end
            if (r && ((pop({6'h0, c4}) != 4'h2) || (c4 == X3_4B))) begin
                c4 = ~c4;
            end
        end
        if (pop({6'h0, c4}) != 4'h2) begin
            r = ~r;
        end
        return {r, c6, c4};
    endfunction

    // Decode one group against the running disparity; resyncs on error.
    function automatic dec_type dec_byte(input logic [9:0] c, input logic rd);
        dec_type    o;
        logic [5:0] c6;
        logic [3:0] c4;
        logic [3:0] p6;
        logic [3:0] p4;
        logic [4:0] x;
        logic [2:0] y;
        logic       f6;
        logic       f4;
        logic       k28;
        logic       kk;
        logic       r6;
        logic       e6;
        logic       e4;
        logic [3:0] t;
        c6  = c[9:4];
        c4  = c[3:0];
        x   = 5'h00;
        y   = 3'h0;
        f6  = 1'b0;
        f4  = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if ((c6 == T6_TAB[i*6 +: 6]) || (c6 == alt6(T6_TAB[i*6 +: 6]))) begin
                f6 = 1'b1;
                x  = 5'(i);
            end
        end
        k28 = (c6 == K28_6B) || (c6 == ~K28_6B);
        if (k28) begin
            f6 = 1'b1;
            x  = 5'h1c;
        end
        kk = k28 || (((x == 5'h17) || (x == 5'h1b) || (x == 5'h1d) || (x == 5'h1e)) &&
                     ((c4 == A7_4B) || (c4 == ~A7_4B)));
        for (int j = 0; j < 8; j++) begin
            t = k28 ? ((c6 == K28_6B) ? ~T4K_TAB[j*4 +: 4] : T4K_TAB[j*4 +: 4]) : T4D_TAB[j*4 +: 4];
            if ((c4 == t) || (!k28 && (c4 == ~t) && ((pop({6'h0, t}) != 4'h2) || (t == X3_4B)))) begin
                f4 = 1'b1;
                y  = 3'(j);
            end
        end
        if (!k28 && ((c4 == A7_4B) || (c4 == ~A7_4B))) begin
            f4 = 1'b1;
            y  = 3'h7;
        end
        p6 = pop({4'h0, c6});
        p4 = pop({6'h0, c4});
        e6 = ((p6 > 4'h3) && rd) || ((p6 < 4'h3) && !rd) || ((c6 == D7_6B) && rd) || ((c6 == ~D7_6B) && !rd);
        r6 = (p6 > 4'h3) ? 1'b1 : ((p6 < 4'h3) ? 1'b0 : rd);
        e4 = ((p4 > 4'h2) && r6) || ((p4 < 4'h2) && !r6) ||
             (!kk && (((c4 == X3_4B) && r6) || ((c4 == ~X3_4B) && !r6)));
        o.data = {y, x};
        o.k    = kk && f6 && f4;
        o.viol = !(f6 && f4);
        o.derr = e6 || e4;
        o.rd   = (p4 > 4'h2) ? 1'b1 : ((p4 < 4'h2) ? 1'b0 : r6);
        return o;
    endfunction

    assign codec_on = cfg_r.codec_en && CODEC_OK && !cfg_r.low_latency;

    // Per-byte bit flips at the fabric side, before the encoder and after the decoder.
    for (genvar b = 0; b < BYTES; b++) begin : g_flip
        for (genvar i = 0; i < 8; i++) begin : g_bit
            assign tx_flipped[b*8+i]  = cfg_r.tx_flip ? tx_data[b*8+7-i] : tx_data[b*8+i];
            assign rx_data_nxt[b*8+i] = cfg_r.rx_flip ? rx_dec_data[b*8+7-i] : rx_dec_data[b*8+i];
        end
    end

    // Encoder chain: disparity ripples from byte 0 upward inside one word.
    always_comb begin
        logic        rd;
        logic [10:0] e;
        rd     = tx_rd_r;
        e      = 11'h000;
        tx_sym = '0;
        for (int b = 0; b < BYTES; b++) begin
            if (tx_force_disp[b]) begin
                rd = tx_disp_val[b];
            end
            e  = enc_byte(tx_flipped[b*8 +: 8], tx_ctrl[b], rd);
            rd = e[10];
            if (codec_on) begin
                tx_sym[b*10 +: 10] = e[9:0];
            end else begin
                tx_sym[b*8 +: 8] = tx_flipped[b*8 +: 8];
            end
        end
        tx_rd_nxt = codec_on ? rd : tx_rd_r;
    end

    // Reversal and polarity in front of the serializer; only the active width is touched.
    always_comb begin
        int aw;
        int grp;
        int g;
        int p;
        aw     = codec_on ? SER_W : BYTES * 8;
        grp    = codec_on ? 10 : 8;
        g      = 0;
        p      = 0;
        if (cfg_r.double_width && (BYTES % 2 == 0)) begin
            grp = grp * 2;
        end
        tx_pre = tx_sym;
        if (cfg_r.tx_bitrev && !cfg_r.low_latency) begin
            for (int i = 0; i < SER_W; i++) begin
                if (i < aw) begin
                    g = i / grp;
                    p = i % grp;
                    tx_pre[g*grp + grp - 1 - p] = tx_sym[i];
                end
            end
        end
        if (tx_inv_polarity && !cfg_r.low_latency) begin
            for (int i = 0; i < SER_W; i++) begin
                if (i < aw) begin
                    tx_pre[i] = ~tx_pre[i];
                end
            end
        end
    end

    // Bitslip: late bits of the previous word fill the low end; a slip beyond the width wraps.
    always_comb begin
        int aw;
        int s;
        aw      = codec_on ? SER_W : BYTES * 8;
        s       = HAS_TX ? (int'(tx_slip_sel) % aw) : 0;
        ser_nxt = tx_pre;
        if (!cfg_r.low_latency) begin
            for (int i = 0; i < SER_W; i++) begin
                if (i < aw) begin
                    ser_nxt[i] = (i >= s) ? tx_pre[i-s] : tx_prev_r[aw-s+i];
                end
            end
        end
    end

    // Transmit word register and running disparity.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ser_word  <= '0;
            tx_prev_r <= '0;
            tx_rd_r   <= RD_RESET;
        end else begin
            ser_word  <= ser_nxt;
            tx_prev_r <= tx_pre;
            tx_rd_r   <= tx_rd_nxt;
        end
    end

    // Decoder chain; in bypass the raw bytes pass and all status bits stay low.
    always_comb begin
        logic    rd;
        dec_type d;
        rd          = rx_rd_r;
        d           = '0;
        rx_dec_data = '0;
        rx_k        = '0;
        rx_v        = '0;
        rx_d        = '0;
        rx_rdb      = '0;
        for (int b = 0; b < BYTES; b++) begin
            if (codec_on) begin
                d                  = dec_byte(rx_ser_word[b*10 +: 10], rd);
                rd                 = d.rd;
                rx_dec_data[b*8 +: 8] = d.data;
                rx_k[b]            = d.k;
                rx_v[b]            = d.viol;
                rx_d[b]            = d.derr;
                rx_rdb[b]          = rd;
            end else begin
                rx_dec_data[b*8 +: 8] = rx_ser_word[b*8 +: 8];
            end
        end
        rx_rd_nxt = rd;
    end

    // Receive outputs: data and per-byte status land on the same edge.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_out_valid <= 1'b0;
            rx_data      <= '0;
            rx_ctrl_det  <= '0;
            rx_err_det   <= '0;
            rx_disp_err  <= '0;
            rx_run_disp  <= '0;
            rx_rd_r      <= RD_RESET;
        end else begin
            rx_out_valid <= rx_valid;
            if (rx_valid) begin
                rx_data     <= rx_data_nxt;
                rx_ctrl_det <= rx_k;
                rx_err_det  <= rx_v | rx_d;
                rx_disp_err <= rx_d;
                rx_run_disp <= cfg_r.rundisp_en ? rx_rdb : '0;
                rx_rd_r     <= rx_rd_nxt;
            end
        end
    end

    // Receive events for the interrupt status.
    assign irq_ev.code_viol = rx_valid && (|rx_v);
    assign irq_ev.disp_err  = rx_valid && (|rx_d);
    assign irq_ev.ctrl_seen = rx_valid && (|rx_k);

    // Bus address phase capture while hready is high; zero wait states, but only NONSEQ transfers are decoded.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ph_wr_r   <= 1'b0;
            ph_rd_r   <= 1'b0;
            ph_addr_r <= 8'h00;
        end else if (hready) begin
            ph_wr_r   <= hsel && (htrans == HTRANS_NONSEQ) && hwrite;
            ph_rd_r   <= hsel && (htrans == HTRANS_NONSEQ) && !hwrite;
            ph_addr_r <= haddr[7:0];
        end
    end

    // Control and mask registers written in the data phase.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r      <= CTRL_RESET;
            irq_mask_r <= MASK_RESET;
        end else if (ph_wr_r) begin
            if (ph_addr_r == OFS_CTRL) begin
                cfg_r <= hwdata[CFG_W-1:0];
            end
            if (ph_addr_r == OFS_IRQ_MASK) begin
                irq_mask_r <= hwdata[IRQ_W-1:0];
            end
        end
    end

    // Sticky status, write one to clear; a new event in the clear cycle is kept.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat_r <= '0;
        end else if (ph_wr_r && (ph_addr_r == OFS_IRQ_STAT)) begin
            irq_stat_r <= (irq_stat_r & ~hwdata[IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    // Read mux off the registered address; unmapped offsets read zero.
    always_comb begin
        hrdata = 32'h0000_0000;
        if (ph_rd_r) begin
            case (ph_addr_r)
                OFS_CTRL:     hrdata = {{(32-CFG_W){1'b0}}, cfg_r};
                OFS_STATUS:   hrdata = {{(32-STAT_W){1'b0}}, rx_rd_r, tx_rd_r, codec_on, CODEC_OK};
                OFS_IRQ_STAT: hrdata = {{(32-IRQ_W){1'b0}}, irq_stat_r};
                OFS_IRQ_MASK: hrdata = {{(32-IRQ_W){1'b0}}, irq_mask_r};
                default:      hrdata = 32'h0000_0000;
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(irq_stat_r & irq_mask_r);
endmodule
`default_nettype wire

/* File: hw/pcs_lane_pkg.sv */
// Shared constants, register layout and code tables for the lane coding block.
`default_nettype none
package pcs_lane_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam int         CFG_W        = 7;
    localparam int         IRQ_W        = 3;
    localparam int         STAT_W       = 4;
    // Codec enabled, everything else off after reset.
    localparam logic [CFG_W-1:0] CTRL_RESET = 7'h02;
    localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam int         DATA_BYTES_DEF = 2;
    localparam int         SLIP_W_DEF     = 5;
    // Running disparity after reset is negative.
    localparam logic       RD_RESET = 1'b0;

    // Control register layout, bit 0 is low_latency.
    typedef struct packed {
        logic rundisp_en;
        logic double_width;
        logic tx_bitrev;
        logic rx_flip;
        logic tx_flip;
        logic codec_en;
        logic low_latency;
    } cfg_type;

    // Interrupt status and mask layout, bit 0 is code_viol.
    typedef struct packed {
        logic ctrl_seen;
        logic disp_err;
        logic code_viol;
    } irq_type;

    // Result of decoding one ten-bit group.
    typedef struct packed {
        logic [7:0] data;
        logic       k;
        logic       viol;
        logic       derr;
        logic       rd;
    } dec_type;

    // Six-bit sub-blocks for negative running disparity, entry 31 first.
    localparam logic [191:0] T6_TAB = {
        6'h2b, 6'h1e, 6'h2e, 6'h0e, 6'h36, 6'h16, 6'h26, 6'h33,
        6'h3a, 6'h1a, 6'h2a, 6'h0b, 6'h32, 6'h13, 6'h23, 6'h1b,
        6'h17, 6'h1c, 6'h2c, 6'h0d, 6'h34, 6'h15, 6'h25, 6'h39,
        6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2d, 6'h1d, 6'h27};
    localparam logic [31:0] T4D_TAB = {4'he, 4'h6, 4'ha, 4'hd, 4'hc, 4'h5, 4'h9, 4'hb};
    localparam logic [31:0] T4K_TAB = {4'h7, 4'h9, 4'h5, 4'hd, 4'hc, 4'ha, 4'h6, 4'hb};
    localparam logic [5:0]  K28_6B  = 6'h0f;
    localparam logic [5:0]  D7_6B   = 6'h38;
    localparam logic [3:0]  X3_4B   = 4'hc;
    localparam logic [3:0]  A7_4B   = 4'h7;
endpackage
`default_nettype wire

/* File: testbench/link_loop_model.sv */
// Serial side model that loops encoded words back into the receiver.
`default_nettype none
module link_loop_model #(
    parameter int W = 20
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic         loop_en,
    input  wire logic         bad,
    input  wire logic [W-1:0] ser_word,
    output logic              rx_valid,
    output logic [W-1:0]      rx_ser_word
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle words toggle so a stale symbol can never pass for a fresh one.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_valid    <= 1'b0;
            rx_ser_word <= '0;
        end else if (loop_en) begin
            rx_valid    <= 1'b1;
            rx_ser_word <= bad ? {ser_word[W-1:10], 10'h000} : ser_word; // All zeros is never a code group.
        end else begin
            rx_valid    <= 1'b0;
            rx_ser_word <= ~rx_ser_word;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/pcs_lane_checker.sv */
// Port-level assertions for the lane coding block.
`default_nettype none
module pcs_lane_checker
    import pcs_lane_pkg::*;
#(
    parameter int BYTES = DATA_BYTES_DEF
) (
    input wire logic               sys_clk,
    input wire logic               rstn,
    input wire logic               hsel,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic [31:0]        hrdata,
    input wire logic               irq,
    input wire logic               rx_valid,
    input wire logic               rx_out_valid,
    input wire logic [BYTES*8-1:0] rx_data,
    input wire logic [BYTES-1:0]   rx_ctrl_det,
    input wire logic [BYTES-1:0]   rx_err_det,
    input wire logic [BYTES-1:0]   rx_disp_err,
    input wire logic [BYTES-1:0]   rx_run_disp
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic dp_wr_r;
    logic dp_rd_r;

    // Marks data phases, since only a write can lower or raise the interrupt on its own.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dp_wr_r <= 1'b0;
            dp_rd_r <= 1'b0;
        end else begin
            dp_wr_r <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
            dp_rd_r <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
        end
    end

    property p_bus_ok;
        hreadyout && !hresp;
    endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus slave stalled or answered an error");
    property p_rx_lat;
        rx_valid |=> rx_out_valid;
    endproperty
    a_rx_lat: assert property (p_rx_lat) else $error("receive result missing");
    property p_rx_idle;
        !rx_valid |=> !rx_out_valid;
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("receive result without input");
    property p_derr_err;
        (rx_disp_err & ~rx_err_det) == '0;
    endproperty
    a_derr_err: assert property (p_derr_err) else $error("disparity error without error flag");
    property p_data_hold;
        !rx_valid |=> $stable(rx_data) && $stable(rx_ctrl_det);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("receive data moved while idle");
    property p_stat_hold;
        !rx_valid |=> $stable({rx_err_det, rx_disp_err, rx_run_disp});
    endproperty
    a_stat_hold: assert property (p_stat_hold) else $error("receive status moved while idle");
    property p_irq_cause;
        $rose(irq) |-> $past(rx_valid) || $past(dp_wr_r);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt rose without cause");
    property p_irq_fall;
        $fell(irq) |-> $past(dp_wr_r);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");
    property p_rdata_idle;
        !dp_rd_r |-> hrdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read phase");

    c_derr: cover property (rx_disp_err != '0);
    c_irq: cover property ($rose(irq));
    c_ctrl: cover property (rx_out_valid && rx_ctrl_det != '0);
endmodule

bind pcs_lane_codec pcs_lane_checker #(.BYTES(BYTES)) chk (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .irq(irq), .rx_valid(rx_valid), .rx_out_valid(rx_out_valid), .rx_data(rx_data), .rx_ctrl_det(rx_ctrl_det),
    .rx_err_det(rx_err_det), .rx_disp_err(rx_disp_err), .rx_run_disp(rx_run_disp));
`default_nettype wire

/* File: testbench/pcs_lane_codec_test.sv */
// Self-checking bench for the lane coding block with a loopback partner.
`default_nettype none
module pcs_lane_codec_test
    import pcs_lane_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        sys_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = 2'h0, tx_ctrl = '0, tx_force = '0, tx_val = '0;
    logic [15:0] tx_data = '0, d, rx_data;
    logic        tx_inv = 1'b0, loop_en = 1'b0, bad = 1'b0;
    logic [4:0]  slip = '0;
    logic        hreadyout, hresp, irq, rx_valid, rx_out_valid;
    logic [19:0] ser_word, rx_ser_word, p, s0, s1;
    logic [1:0]  rx_ctrl_det, rx_err_det, rx_disp_err, rx_run_disp;
    logic [7:0]  kc [12] = '{8'h1c, 8'h3c, 8'h5c, 8'h7c, 8'h9c, 8'hbc, 8'hdc, 8'hfc, 8'hf7, 8'hfb, 8'hfd, 8'hfe};
    int          n_fail = 0, tests_run = 0;

    always #25 sys_clk = ~sys_clk;

    pcs_lane_codec DUT (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq(irq), .tx_data(tx_data), .tx_ctrl(tx_ctrl),
        .tx_force_disp(tx_force), .tx_disp_val(tx_val), .tx_inv_polarity(tx_inv), .tx_slip_sel(slip),
        .ser_word(ser_word), .rx_valid(rx_valid), .rx_ser_word(rx_ser_word), .rx_out_valid(rx_out_valid),
        .rx_data(rx_data), .rx_ctrl_det(rx_ctrl_det), .rx_err_det(rx_err_det), .rx_disp_err(rx_disp_err),
        .rx_run_disp(rx_run_disp));

    link_loop_model #(.W(20)) loopback (.sys_clk(sys_clk), .rstn(rstn), .loop_en(loop_en), .bad(bad),
        .ser_word(ser_word), .rx_valid(rx_valid), .rx_ser_word(rx_ser_word));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One single AHB transfer; the wait loops never assume a fixed latency.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic tx(input logic [15:0] dv, input logic [1:0] c, input logic [1:0] f, input logic [1:0] v);
        @(posedge sys_clk);
        tx_data  <= dv;
        tx_ctrl  <= c;
        tx_force <= f;
        tx_val   <= v;
    endtask

    // Ends just after an edge so outputs have settled before they are read.
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [19:0] rev(input logic [19:0] x, input int n);
        rev = '0;
        for (int i = 0; i < n; i++) rev[i] = x[n-1-i];
    endfunction

    function automatic logic [15:0] flip(input logic [15:0] x);
        for (int i = 0; i < 16; i++) flip[i] = x[(i/8)*8 + 7 - i%8];
    endfunction

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        void'($urandom(68));
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        bus(0, OFS_CTRL, 0); check(rd, 32'h2);
        bus(0, OFS_STATUS, 0); check(rd[1:0], 2'h3);
        bus(0, OFS_IRQ_STAT, 0); check(rd, 32'h0);
        bus(0, OFS_IRQ_MASK, 0); check(rd, 32'h0);
        bus(1, 8'h10, 32'hffff_ffff); bus(0, 8'h10, 0); check(rd, 32'h0);
        $display("test registers done");
        // K28.5 forced negative twice in a row breaks the running disparity on every group.
        bus(1, OFS_CTRL, 32'h42);
        loop_en <= 1'b1;
        tx(16'hbcbc, 2'h3, 2'h3, 2'h0); hold(5);
        check(ser_word, {10'h0fa, 10'h0fa});
        check({rx_err_det, rx_disp_err}, 4'hf);
        tx(16'hbcbc, 2'h3, 2'h3, 2'h2); hold(5);
        p = {10'h305, 10'h0fa};
        check(ser_word, p);
        check({rx_disp_err, rx_err_det, rx_ctrl_det, rx_data}, {6'h3, 16'hbcbc});
        check(rx_run_disp, 2'h1);
        $display("test forced disparity done");
        @(posedge sys_clk); tx_inv <= 1'b1; hold(3);
        check(ser_word, {10'h0fa, 10'h305});
        @(posedge sys_clk); tx_inv <= 1'b0; slip <= 5'd3; hold(3);
        check(ser_word, {p[16:0], p[19:17]});
        @(posedge sys_clk); slip <= 5'd0;
        bus(1, OFS_CTRL, 32'h52); hold(3);
        s1 = rev(p[19:10], 10);
        s0 = rev(p[9:0], 10);
        check(ser_word, {s1[9:0], s0[9:0]});
        bus(1, OFS_CTRL, 32'h72); hold(3);
        check(ser_word, rev(p, 20));
        $display("test serializer word done");
        d = 16'($urandom);
        bus(1, OFS_CTRL, 32'h73);
        @(posedge sys_clk); tx_inv <= 1'b1; slip <= 5'd3;
        tx(d, 2'h0, 2'h0, 2'h0); hold(5);
        check(ser_word, {4'h0, d});
        check({rx_ctrl_det, rx_err_det, rx_disp_err, rx_data}, {6'h0, d});
        $display("test low latency done");
        bus(1, OFS_CTRL, 32'h42);
        @(posedge sys_clk); tx_inv <= 1'b0; slip <= 5'd0;
        foreach (kc[i]) begin
            d = {8'($urandom), kc[i]};
            tx(d, 2'h1, 2'h0, 2'h0); hold(5);
            check({rx_ctrl_det, rx_err_det, rx_data}, {4'h4, d});
            check(32'($countones(ser_word[9:0]) inside {4, 5, 6}), 32'h1);
        end
        $display("test control codes done");
        for (int m = 1; m < 4; m++) begin
            d = 16'($urandom);
            bus(1, OFS_CTRL, 32'(2 + 4 * m));
            tx(d, 2'h0, 2'h0, 2'h0); hold(5);
            check(rx_data, (m == 3) ? d : flip(d));
            check(rx_run_disp, 2'h0);
        end
        $display("test byte flips done");
        // A violation while masked must not raise the interrupt line.
        bus(1, OFS_CTRL, 32'h42);
        bus(1, OFS_IRQ_STAT, 32'h7);
        @(posedge sys_clk); bad <= 1'b1; hold(4);
        check({irq, rx_err_det[0]}, 2'h1);
        bus(1, OFS_IRQ_MASK, 32'h1); #1;
        check(irq, 32'h1);
        @(posedge sys_clk); bad <= 1'b0; hold(4);
        bus(1, OFS_IRQ_STAT, 32'h1); #1;
        check(irq, 32'h0);
        bus(0, OFS_IRQ_STAT, 0); check(rd[0], 32'h0);
        $display("test interrupt done");
        end_of_test();
    end
endmodule
`default_nettype wire
